/* core/qplr_op_map.sv */
// module: maps a queue operation to its entries and write list
`timescale 1ns/1ps
`default_nettype none
module qplr_op_map (
  input wire qplr_pkg::qplr_op_e op_i,
  input wire logic [1:0] chan_i,
  input wire logic [27:0] ptr_i,
  input wire logic [27:0] loc_i,
  output logic [4:0] rd_addr_o,
  output logic [3:0] lim_addr_o,
  output logic lim_check_o,
  output logic [1:0] wr_cnt_o,
  output logic [2:0][4:0] wr_addr_o,
  output logic [2:0][27:0] wr_data_o
);

  logic [4:0] tx_base;
  logic [4:0] rx_base;
  logic [3:0] ltx;
  logic [3:0] lrx;

  always_comb begin
    // ----------------------------------------------------------------
    // channel groups
    // ----------------------------------------------------------------
    tx_base = chan_i[0] ? qplr_pkg::TX_DATA_PTR_CHAN1 : qplr_pkg::TX_DATA_PTR_CHAN0;
    ltx = chan_i[0] ? qplr_pkg::LIM_TX_CHAN1_BASE : qplr_pkg::LIM_TX_CHAN0_BASE;
    case (chan_i)
      2'h2: begin
        rx_base = qplr_pkg::RX_DATA_PTR_CHAN2;
        lrx = qplr_pkg::LIM_RX_CHAN2_BASE;
      end
      2'h1: begin
        rx_base = qplr_pkg::RX_CHAN1_BASE;
        lrx = qplr_pkg::LIM_RX_CHAN1_BASE;
      end
      default: begin
        rx_base = qplr_pkg::RX_CHAN0_BASE;
        lrx = qplr_pkg::LIM_RX_CHAN0_BASE;
      end
    endcase
    rd_addr_o = tx_base;
    lim_addr_o = ltx;
    lim_check_o = 1'b0;
    wr_cnt_o = 2'h0;
    wr_addr_o = '0;
    wr_data_o = '0;
    // ----------------------------------------------------------------
    // per operation
    // ----------------------------------------------------------------
    case (op_i)
      qplr_pkg::OP_TX_JOB_FETCH: begin
        rd_addr_o = tx_base + qplr_pkg::TX_JOB_OFS;
        lim_addr_o = ltx + qplr_pkg::LIM_JOB_OFS;
        lim_check_o = 1'b1;
        wr_cnt_o = 2'h2;
        wr_addr_o[0] = tx_base + qplr_pkg::TX_JOB_OFS;
        wr_data_o[0] = ptr_i + qplr_pkg::PTR_STEP;
        wr_addr_o[1] = tx_base + qplr_pkg::TX_LIST_OFS;
        wr_data_o[1] = loc_i;
      end
      qplr_pkg::OP_TX_UNIT_FETCH: begin
        rd_addr_o = tx_base + qplr_pkg::TX_LIST_OFS;
        wr_cnt_o = 2'h3;
        wr_addr_o[0] = qplr_pkg::TX_SHADOW_PTR;
        wr_data_o[0] = ptr_i;
        wr_addr_o[1] = tx_base + qplr_pkg::TX_LIST_OFS;
        wr_data_o[1] = ptr_i + qplr_pkg::PTR_STEP;
        wr_addr_o[2] = tx_base + qplr_pkg::TX_DATA_OFS;
        wr_data_o[2] = loc_i;
      end
      qplr_pkg::OP_CMPL_WRITE: begin
        rd_addr_o = tx_base + qplr_pkg::TX_CMPL_OFS;
        lim_addr_o = ltx + qplr_pkg::LIM_CMPL_OFS;
        wr_cnt_o = 2'h1;
        wr_addr_o[0] = tx_base + qplr_pkg::TX_CMPL_OFS;
        wr_data_o[0] = ptr_i + qplr_pkg::PTR_STEP;
      end
      qplr_pkg::OP_FREE_FETCH: begin
        rd_addr_o = rx_base + qplr_pkg::RX_FREEQ_OFS;
        lim_addr_o = lrx + qplr_pkg::LIM_FREE_OFS;
        lim_check_o = 1'b1;
        wr_cnt_o = 2'h2;
        wr_addr_o[0] = rx_base + qplr_pkg::RX_NEXT_FREE_OFS;
        wr_data_o[0] = loc_i;
        wr_addr_o[1] = rx_base + qplr_pkg::RX_FREEQ_OFS;
        wr_data_o[1] = ptr_i + qplr_pkg::PTR_STEP;
      end
      qplr_pkg::OP_FREE_TAKE: begin
        rd_addr_o = rx_base + qplr_pkg::RX_NEXT_FREE_OFS;
        wr_cnt_o = 2'h1;
        wr_addr_o[0] = rx_base + qplr_pkg::RX_DATA_OFS;
        wr_data_o[0] = ptr_i;
      end
      qplr_pkg::OP_RX_DESC_STORE: begin
        rd_addr_o = rx_base + qplr_pkg::RX_DESCQ_OFS;
        lim_addr_o = lrx + qplr_pkg::LIM_DESC_OFS;
        lim_check_o = 1'b1;
        wr_cnt_o = 2'h1;
        wr_addr_o[0] = rx_base + qplr_pkg::RX_DESCQ_OFS;
        wr_data_o[0] = ptr_i + qplr_pkg::PTR_STEP;
      end
      qplr_pkg::OP_RX_DATA_DONE: begin
        rd_addr_o = rx_base + qplr_pkg::RX_DATA_OFS;
        wr_cnt_o = 2'h1;
        wr_addr_o[0] = qplr_pkg::RX_SHADOW_PTR;
        wr_data_o[0] = ptr_i;
      end
      default: begin
        wr_cnt_o = 2'h0;
      end
    endcase
  end

endmodule : qplr_op_map
`default_nettype wire

/* core/qplr_pkg.sv */
// package: constants and types of the queue pointer and limit store
package qplr_pkg;

  // ----------------------------------------------------------------
  // array shapes
  // ----------------------------------------------------------------
  localparam int PTR_W = 28;
  localparam int PTR_AW = 5;
  localparam int PTR_DEPTH = 32;
  localparam int LIM_W = 9;
  localparam int LIM_AW = 4;
  localparam int LIM_DEPTH = 16;

  // ----------------------------------------------------------------
  // pointer array entries
  // ----------------------------------------------------------------
  localparam logic [4:0] TX_DATA_PTR_CHAN1 = 5'h00;
  localparam logic [4:0] TX_DESC_LIST_PTR_CHAN1 = 5'h01;
  localparam logic [4:0] COMPLETION_QUEUE_PTR_CHAN1 = 5'h02;
  localparam logic [4:0] TX_JOB_QUEUE_PTR_CHAN1 = 5'h03;
  localparam logic [4:0] TX_DATA_PTR_CHAN0 = 5'h04;
  localparam logic [4:0] TX_DESC_LIST_PTR_CHAN0 = 5'h05;
  localparam logic [4:0] COMPLETION_QUEUE_PTR_CHAN0 = 5'h06;
  localparam logic [4:0] TX_JOB_QUEUE_PTR_CHAN0 = 5'h07;
  localparam logic [4:0] RX_DATA_PTR_CHAN2 = 5'h08;
  localparam logic [4:0] RX_DESC_QUEUE_PTR_CHAN2 = 5'h09;
  localparam logic [4:0] RX_CHAN1_BASE = 5'h0C;
  localparam logic [4:0] RX_CHAN0_BASE = 5'h10;
  localparam logic [4:0] RX_SHADOW_PTR = 5'h14;
  localparam logic [4:0] TX_SHADOW_PTR = 5'h15;

  // offsets inside a channel group
  localparam logic [4:0] TX_DATA_OFS = 5'h00;
  localparam logic [4:0] TX_LIST_OFS = 5'h01;
  localparam logic [4:0] TX_CMPL_OFS = 5'h02;
  localparam logic [4:0] TX_JOB_OFS = 5'h03;
  localparam logic [4:0] RX_DATA_OFS = 5'h00;
  localparam logic [4:0] RX_DESCQ_OFS = 5'h01;
  localparam logic [4:0] RX_FREEQ_OFS = 5'h02;
  localparam logic [4:0] RX_NEXT_FREE_OFS = 5'h03;

  // ----------------------------------------------------------------
  // limit array entries
  // ----------------------------------------------------------------
  localparam logic [3:0] LIM_TX_CHAN1_BASE = 4'h0;
  localparam logic [3:0] LIM_TX_CHAN0_BASE = 4'h2;
  localparam logic [3:0] LIM_RX_CHAN2_BASE = 4'h4;
  localparam logic [3:0] LIM_RX_CHAN1_BASE = 4'h6;
  localparam logic [3:0] LIM_RX_CHAN0_BASE = 4'h8;
  localparam logic [3:0] LIM_JOB_OFS = 4'h0;
  localparam logic [3:0] LIM_CMPL_OFS = 4'h1;
  localparam logic [3:0] LIM_DESC_OFS = 4'h0;
  localparam logic [3:0] LIM_FREE_OFS = 4'h1;

  // ----------------------------------------------------------------
  // stepping and reset values
  // ----------------------------------------------------------------
  localparam logic [27:0] PTR_STEP = 28'h0000001;
  localparam logic [8:0] CMPL_WARN_GAP = 9'h001;
  localparam logic [27:0] RDATA_RST = 28'h0000000;

  typedef enum logic [2:0] {
    OP_TX_JOB_FETCH,
    OP_TX_UNIT_FETCH,
    OP_CMPL_WRITE,
    OP_FREE_FETCH,
    OP_FREE_TAKE,
    OP_RX_DESC_STORE,
    OP_RX_DATA_DONE
  } qplr_op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOST_RD,
    ST_EVAL,
    ST_WRITE
  } qplr_st_e;

endpackage : qplr_pkg

/* core/qplr_ram.sv */
// module: single port array with registered read data
`timescale 1ns/1ps
`default_nettype none
module qplr_ram #(
  parameter int AW = 5,
  parameter int DW = 28,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  qplr_ram_if.slave bus
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } qplr_ram_s;

  qplr_ram_s q;
  qplr_ram_s d;

  always_comb begin
    d = q;
    if (bus.en) begin
      if (bus.we) begin
        d.mem[bus.addr] = bus.wdata;
      end else begin
        d.rdata = q.mem[bus.addr];
      end
    end
  end

  // contents are not cleared by reset
  always_ff @(posedge clk_i) begin
    q.mem <= d.mem;
    if (!rst_n_i) begin
      q.rdata <= '0;
    end else begin
      q.rdata <= d.rdata;
    end
  end

  assign bus.rdata = q.rdata;

endmodule : qplr_ram
`default_nettype wire

/* core/qplr_ram_if.sv */
// interface: one port of a small synchronous array
`timescale 1ns/1ps
`default_nettype none
interface qplr_ram_if #(
  parameter int AW = 5,
  parameter int DW = 28
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport master (output en, output we, output addr, output wdata, input rdata);
  modport slave (input en, input we, input addr, input wdata, output rdata);
endinterface : qplr_ram_if
`default_nettype wire

/* core/qplr_top.sv */
// module: queue pointer and limit store with its update sequencer
// How it works
// - unit descriptor fetch loads the channel data pointer from its location
// - job descriptor fetch loads the descriptor list pointer from its location
// - list pointer steps by one per unit descriptor fetched
// - completion queue pointer steps after every completion record written
// - job queue pointer steps on every job descriptor fetched
// - taking the next free buffer copies it into the receive data pointer
// - host sets receive descriptor queue pointer; device steps it per store
// - host sets free-buffer queue pointer; device steps it per fetch
// - fetched free-buffer descriptor is kept as the next free buffer
// - receive shadow keeps start of the latest receive data unit stored
// - transmit shadow keeps address of the unit descriptor being handled
// - limit array is sixteen nine-bit entries; entries eleven up unusable
// - hardware reads limits itself to bound the job, receive descriptor and free-buffer queues
// - no job descriptor fetch beyond the job queue limit
// - next-to-last completion write raises no-status-space; one more may follow
// - no receive descriptor store beyond the descriptor queue limit
// - no free-buffer fetch beyond the free-buffer queue limit
// - transmit one at 00, transmit zero at 04, receive two from 08
// - pointer array is thirty-two 28-bit entries reached by host command
`timescale 1ns/1ps
`default_nettype none
module qplr_top (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HOST_CMD_VALID_I,
  input wire logic HOST_CMD_LIMIT_I,
  input wire logic HOST_CMD_WRITE_I,
  input wire logic [4:0] HOST_CMD_ADDR_I,
  input wire logic [27:0] HOST_CMD_WDATA_I,
  output logic HOST_CMD_READY_O,
  output logic HOST_DONE_O,
  output logic [27:0] HOST_RDATA_O,
  input wire logic OP_VALID_I,
  input wire logic [2:0] OP_CODE_I,
  input wire logic [1:0] OP_CHAN_I,
  input wire logic [27:0] OP_LOC_I,
  output logic OP_READY_O,
  output logic OP_DONE_O,
  output logic OP_REFUSED_O,
  output logic [27:0] OP_ADDR_O,
  output logic NO_STATUS_SPACE_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    qplr_pkg::qplr_st_e st;
    qplr_pkg::qplr_op_e op;
    logic [1:0] chan;
    logic [27:0] loc;
    logic [27:0] ptr;
    logic [1:0] wr_idx;
    logic host_lim;
    logic [27:0] host_rdata;
    logic host_done;
    logic op_done;
    logic op_refused;
    logic [27:0] op_addr;
    logic nss;
  } qplr_state_s;

  qplr_state_s q;
  qplr_state_s d;

  qplr_pkg::qplr_op_e op_in;
  qplr_pkg::qplr_op_e map_op;
  logic [1:0] map_chan;
  logic [4:0] map_rd_addr;
  logic [3:0] map_lim_addr;
  logic map_lim_check;
  logic [1:0] map_wr_cnt;
  logic [2:0][4:0] map_wr_addr;
  logic [2:0][27:0] map_wr_data;
  logic exhausted;
  logic cmpl_warn;

  // ----------------------------------------------------------------
  // arrays
  // ----------------------------------------------------------------
  qplr_ram_if #(.AW(qplr_pkg::PTR_AW), .DW(qplr_pkg::PTR_W)) ptr_bus ();
  qplr_ram_if #(.AW(qplr_pkg::LIM_AW), .DW(qplr_pkg::LIM_W)) lim_bus ();

  qplr_ram #(
    .AW(qplr_pkg::PTR_AW),
    .DW(qplr_pkg::PTR_W),
    .DEPTH(qplr_pkg::PTR_DEPTH)
  ) u_ptr_ram (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .bus(ptr_bus.slave)
  );

  qplr_ram #(
    .AW(qplr_pkg::LIM_AW),
    .DW(qplr_pkg::LIM_W),
    .DEPTH(qplr_pkg::LIM_DEPTH)
  ) u_lim_ram (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .bus(lim_bus.slave)
  );

  // ----------------------------------------------------------------
  // operation map
  // ----------------------------------------------------------------
  assign op_in = qplr_pkg::qplr_op_e'(OP_CODE_I);
  assign map_op = (q.st == qplr_pkg::ST_IDLE) ? op_in : q.op;
  assign map_chan = (q.st == qplr_pkg::ST_IDLE) ? OP_CHAN_I : q.chan;

  qplr_op_map u_op_map (
    .op_i(map_op),
    .chan_i(map_chan),
    .ptr_i(q.ptr),
    .loc_i(q.loc),
    .rd_addr_o(map_rd_addr),
    .lim_addr_o(map_lim_addr),
    .lim_check_o(map_lim_check),
    .wr_cnt_o(map_wr_cnt),
    .wr_addr_o(map_wr_addr),
    .wr_data_o(map_wr_data)
  );

  // limit checks on the freshly read entries
  assign exhausted = map_lim_check && (ptr_bus.rdata[8:0] == lim_bus.rdata);
  assign cmpl_warn = (q.op == qplr_pkg::OP_CMPL_WRITE)
                     && (ptr_bus.rdata[8:0] == (lim_bus.rdata - qplr_pkg::CMPL_WARN_GAP));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.host_done = 1'b0;
    d.op_done = 1'b0;
    d.op_refused = 1'b0;
    d.nss = 1'b0;
    ptr_bus.en = 1'b0;
    ptr_bus.we = 1'b0;
    ptr_bus.addr = map_rd_addr;
    ptr_bus.wdata = '0;
    lim_bus.en = 1'b0;
    lim_bus.we = 1'b0;
    lim_bus.addr = map_lim_addr;
    lim_bus.wdata = '0;
    case (q.st)
      qplr_pkg::ST_IDLE: begin
        if (HOST_CMD_VALID_I) begin
          d.host_lim = HOST_CMD_LIMIT_I;
          if (HOST_CMD_LIMIT_I) begin
            lim_bus.en = 1'b1;
            lim_bus.we = HOST_CMD_WRITE_I;
            lim_bus.addr = HOST_CMD_ADDR_I[3:0];
            lim_bus.wdata = HOST_CMD_WDATA_I[8:0];
          end else begin
            ptr_bus.en = 1'b1;
            ptr_bus.we = HOST_CMD_WRITE_I;
            ptr_bus.addr = HOST_CMD_ADDR_I;
            ptr_bus.wdata = HOST_CMD_WDATA_I;
          end
          if (HOST_CMD_WRITE_I) begin
            d.host_done = 1'b1;
          end else begin
            d.st = qplr_pkg::ST_HOST_RD;
          end
        end else if (OP_VALID_I) begin
          ptr_bus.en = 1'b1;
          lim_bus.en = 1'b1;
          d.op = op_in;
          d.chan = OP_CHAN_I;
          d.loc = OP_LOC_I;
          d.st = qplr_pkg::ST_EVAL;
        end
      end
      qplr_pkg::ST_HOST_RD: begin
        d.host_rdata = q.host_lim ? {{(qplr_pkg::PTR_W - qplr_pkg::LIM_W){1'b0}}, lim_bus.rdata}
                                  : ptr_bus.rdata;
        d.host_done = 1'b1;
        d.st = qplr_pkg::ST_IDLE;
      end
      qplr_pkg::ST_EVAL: begin
        d.ptr = ptr_bus.rdata;
        d.op_addr = ptr_bus.rdata;
        d.wr_idx = 2'h0;
        d.nss = cmpl_warn;
        if (exhausted) begin
          d.op_done = 1'b1;
          d.op_refused = 1'b1;
          d.st = qplr_pkg::ST_IDLE;
        end else if (map_wr_cnt == 2'h0) begin
          // unknown operation code: finish without touching the array
          d.op_done = 1'b1;
          d.st = qplr_pkg::ST_IDLE;
        end else begin
          d.st = qplr_pkg::ST_WRITE;
        end
      end
      qplr_pkg::ST_WRITE: begin
        ptr_bus.en = 1'b1;
        ptr_bus.we = 1'b1;
        ptr_bus.addr = map_wr_addr[q.wr_idx];
        ptr_bus.wdata = map_wr_data[q.wr_idx];
        d.wr_idx = q.wr_idx + 2'h1;
        if (q.wr_idx == (map_wr_cnt - 2'h1)) begin
          d.op_done = 1'b1;
          d.st = qplr_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = qplr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HOST_CMD_READY_O = (q.st == qplr_pkg::ST_IDLE);
  assign OP_READY_O = (q.st == qplr_pkg::ST_IDLE) && !HOST_CMD_VALID_I;
  assign HOST_DONE_O = q.host_done;
  assign HOST_RDATA_O = q.host_rdata;
  assign OP_DONE_O = q.op_done;
  assign OP_REFUSED_O = q.op_refused;
  assign OP_ADDR_O = q.op_addr;
  assign NO_STATUS_SPACE_O = q.nss;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_op_done_bound: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (OP_VALID_I && OP_READY_O) |-> ##[2:5] OP_DONE_O)
    else $error("operation did not finish in time");

  chk_refuse_exhausted: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (q.st == qplr_pkg::ST_EVAL && map_lim_check && ptr_bus.rdata[8:0] == lim_bus.rdata)
    |=> (OP_REFUSED_O && OP_DONE_O && q.st != qplr_pkg::ST_WRITE))
    else $error("exhausted queue was not refused");

  chk_refused_no_write: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    OP_REFUSED_O |-> (q.st == qplr_pkg::ST_IDLE && $past(q.st) == qplr_pkg::ST_EVAL))
    else $error("refusal came after writes");

  chk_tx_shadow: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (q.st == qplr_pkg::ST_WRITE && q.op == qplr_pkg::OP_TX_UNIT_FETCH && q.wr_idx == 2'h0)
    |-> (ptr_bus.addr == qplr_pkg::TX_SHADOW_PTR && ptr_bus.wdata == q.op_addr))
    else $error("transmit shadow not loaded");

  chk_list_step: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (q.st == qplr_pkg::ST_WRITE && q.op == qplr_pkg::OP_TX_UNIT_FETCH && q.wr_idx == 2'h1)
    |-> (ptr_bus.wdata == q.op_addr + qplr_pkg::PTR_STEP) ##1 (ptr_bus.wdata == q.loc))
    else $error("list pointer or data pointer wrong");

  chk_job_fetch: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (q.st == qplr_pkg::ST_EVAL && q.op == qplr_pkg::OP_TX_JOB_FETCH && !exhausted)
    |=> (ptr_bus.we && ptr_bus.wdata == $past(ptr_bus.rdata) + qplr_pkg::PTR_STEP)
        ##1 (ptr_bus.we && ptr_bus.wdata == q.loc) ##1 OP_DONE_O)
    else $error("job fetch sequence wrong");

  chk_nss_cause: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    NO_STATUS_SPACE_O |-> ($past(q.op) == qplr_pkg::OP_CMPL_WRITE
                           && $past(q.st) == qplr_pkg::ST_EVAL))
    else $error("no-status-space without completion write");

  chk_cmpl_not_refused: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (q.st == qplr_pkg::ST_EVAL && q.op == qplr_pkg::OP_CMPL_WRITE) |=> ##1 OP_DONE_O && !OP_REFUSED_O)
    else $error("completion write was refused");

  chk_host_read: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (HOST_CMD_VALID_I && HOST_CMD_READY_O && !HOST_CMD_WRITE_I) |-> ##2 HOST_DONE_O)
    else $error("host read not answered");

  chk_host_first: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (HOST_CMD_VALID_I && HOST_CMD_READY_O) |=> (q.st != qplr_pkg::ST_EVAL))
    else $error("operation taken over a host command");

endmodule : qplr_top
`default_nettype wire

/* dv/qplr_host_model.sv */
// host model: issues pointer and limit array service commands
`timescale 1ns/1ps
`default_nettype none
module qplr_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic done_i,
  output logic valid_o,
  output logic limit_o,
  output logic write_o,
  output logic [4:0] addr_o,
  output logic [27:0] wdata_o
);
  initial begin
    valid_o = 1'b0;
    limit_o = 1'b0;
    write_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 28'h0000000;
  end

  // ----------------------------------------------------------------
  // one command: held until taken or 20 cycles pass, then bounded wait for completion
  // ----------------------------------------------------------------
  task automatic cmd(input logic lim, input logic wr, input logic [4:0] a,
                     input logic [27:0] d, output logic ok);
    int n;
    ok = 1'b0;
    n = 0;
    if (lim && a > 5'h0A) return;
    @(negedge clk_i);
    valid_o = 1'b1;
    limit_o = lim;
    write_o = wr;
    addr_o = a;
    wdata_o = d;
    #1;
    while (ready_i !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    // a write answers in the cycle right after it is taken
    #1;
    ok = done_i;
    @(negedge clk_i);
    valid_o = 1'b0;
    wdata_o = ~d;
    n = 0;
    while (ok !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      ok = done_i;
      n++;
    end
  endtask : cmd
endmodule : qplr_host_model
`default_nettype wire

/* dv/queue_pointer_limit_ram_test.sv */
// testbench: queue pointer and limit store
`timescale 1ns/1ps
`default_nettype none
module queue_pointer_limit_ram_test;
  typedef struct packed {
    logic [2:0] c;
    logic [1:0] ch;
    logic [27:0] loc;
    logic [27:0] adr;
    logic [2:0] f;
    logic [4:0] ea;
    logic [27:0] va;
    logic [4:0] eb;
    logic [27:0] vb;
  } qplr_row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hv, hl, hw, hrdy, hdone, ov, ordy, odone, oref, nss, ok, r, ns, dn;
  logic [4:0] ha;
  logic [27:0] hd, hrd, ol, oadr, a;
  logic [2:0] oc = 3'h0;
  logic [1:0] och = 2'h0;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  // f holds {skip address, refused, no status space}
  qplr_row_s rows [14] = '{
    '{3'h0, 2'h1, 28'h0ABC000, 28'h0000100, 3'h0,
      5'h01, 28'h0ABC000, 5'h03, 28'h0000101},
    '{3'h0, 2'h1, 28'h0DEF000, 28'h0000101, 3'h0,
      5'h01, 28'h0DEF000, 5'h03, 28'h0000102},
    '{3'h0, 2'h1, 28'h0FFF000, 28'h0000102, 3'h2,
      5'h01, 28'h0DEF000, 5'h03, 28'h0000102},
    '{3'h1, 2'h1, 28'h0123450, 28'h0DEF000, 3'h0,
      5'h00, 28'h0123450, 5'h01, 28'h0DEF001},
    '{3'h1, 2'h1, 28'h0555550, 28'h0DEF001, 3'h0,
      5'h15, 28'h0DEF001, 5'h00, 28'h0555550},
    '{3'h2, 2'h1, 28'h0000000, 28'h0000202, 3'h1,
      5'h02, 28'h0000203, 5'h02, 28'h0000203},
    '{3'h2, 2'h1, 28'h0000000, 28'h0000203, 3'h0,
      5'h02, 28'h0000204, 5'h02, 28'h0000204},
    '{3'h3, 2'h2, 28'h0777770, 28'h0000300, 3'h0,
      5'h0B, 28'h0777770, 5'h0A, 28'h0000301},
    '{3'h3, 2'h2, 28'h0111110, 28'h0000301, 3'h2,
      5'h0B, 28'h0777770, 5'h0A, 28'h0000301},
    '{3'h4, 2'h2, 28'h0000000, 28'h0000000, 3'h4,
      5'h08, 28'h0777770, 5'h0B, 28'h0777770},
    '{3'h5, 2'h2, 28'h0000000, 28'h0000400, 3'h0,
      5'h09, 28'h0000401, 5'h09, 28'h0000401},
    '{3'h5, 2'h2, 28'h0000000, 28'h0000401, 3'h2,
      5'h09, 28'h0000401, 5'h09, 28'h0000401},
    '{3'h6, 2'h2, 28'h0000000, 28'h0000000, 3'h4,
      5'h14, 28'h0777770, 5'h08, 28'h0777770},
    '{3'h0, 2'h0, 28'h0B0B000, 28'h0000500, 3'h0,
      5'h05, 28'h0B0B000, 5'h07, 28'h0000501}
  };

  always #2.5 clk = ~clk;

  qplr_top uut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .HOST_CMD_VALID_I(hv), .HOST_CMD_LIMIT_I(hl),
    .HOST_CMD_WRITE_I(hw), .HOST_CMD_ADDR_I(ha), .HOST_CMD_WDATA_I(hd),
    .HOST_CMD_READY_O(hrdy), .HOST_DONE_O(hdone), .HOST_RDATA_O(hrd), .OP_VALID_I(ov),
    .OP_CODE_I(oc), .OP_CHAN_I(och), .OP_LOC_I(ol), .OP_READY_O(ordy), .OP_DONE_O(odone),
    .OP_REFUSED_O(oref), .OP_ADDR_O(oadr), .NO_STATUS_SPACE_O(nss)
  );

  qplr_host_model host (
    .clk_i(clk), .ready_i(hrdy), .done_i(hdone), .valid_o(hv), .limit_o(hl),
    .write_o(hw), .addr_o(ha), .wdata_o(hd)
  );

  // ----------------------------------------------------------------
  // compare, access and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input string nm, input logic [27:0] e, input logic [27:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : cmp_val

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %b seen %b", nm, e, g);
      num_errors++;
    end
  endtask : cmp_bit

  task automatic hwr(input logic lim, input logic [4:0] ad, input logic [27:0] d);
    host.cmd(lim, 1'b1, ad, d, ok);
    cmp_bit("write done", 1'b1, ok);
  endtask : hwr

  task automatic hchk(input logic lim, input logic [4:0] ad, input logic [27:0] e);
    host.cmd(lim, 1'b0, ad, 28'h0000000, ok);
    cmp_bit("read done", 1'b1, ok);
    cmp_val("entry", e, hrd);
  endtask : hchk

  task automatic op(input qplr_row_s w);
    @(negedge clk);
    ov = 1'b1;
    oc = w.c;
    och = w.ch;
    ol = w.loc;
    #1;
    while (ordy !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    ov = 1'b0;
    ol = ~w.loc;
    ns = 1'b0;
    dn = 1'b0;
    for (int k = 0; k < 10 && dn !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      ns = ns | nss;
      dn = odone;
    end
    r = oref;
    a = oadr;
  endtask : op

  task automatic chk_rst();
    cmp_bit("host done", 1'b0, hdone);
    cmp_bit("op done", 1'b0, odone);
    cmp_bit("host ready", 1'b1, hrdy);
    cmp_bit("op ready", 1'b1, ordy);
    cmp_val("read data", qplr_pkg::RDATA_RST, hrd);
  endtask : chk_rst

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ov = 1'b0;
    ol = 28'h0000000;
    repeat (10) @(negedge clk);
    chk_rst();
    rst_n = 1'b1;
    hwr(1'b0, 5'h03, 28'h0000100);
    hwr(1'b0, 5'h02, 28'h0000202);
    hwr(1'b0, 5'h07, 28'h0000500);
    hwr(1'b0, 5'h0A, 28'h0000300);
    hwr(1'b0, 5'h09, 28'h0000400);
    hwr(1'b1, 5'h00, 28'h0000102);
    hwr(1'b1, 5'h01, 28'h0000203);
    hwr(1'b1, 5'h02, 28'h0000510);
    hwr(1'b1, 5'h04, 28'h0000401);
    hwr(1'b1, 5'h05, 28'h0000301);
    foreach (rows[i]) begin
      op(rows[i]);
      cmp_bit("op done", 1'b1, dn);
      if (!rows[i].f[2]) cmp_val("op address", rows[i].adr, a);
      cmp_bit("refused", rows[i].f[1], r);
      cmp_bit("no status space", rows[i].f[0], ns);
      hchk(1'b0, rows[i].ea, rows[i].va);
      hchk(1'b0, rows[i].eb, rows[i].vb);
    end
    hwr(1'b1, 5'h0A, 28'hFFFFFFF);
    hchk(1'b1, 5'h0A, 28'h00001FF);
    hwr(1'b0, 5'h0D, 28'hFFFFFFF);
    hchk(1'b0, 5'h0D, 28'hFFFFFFF);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk_rst();
    rst_n = 1'b1;
    hchk(1'b0, 5'h01, 28'h0DEF002);
    tally_and_finish();
  end
endmodule : queue_pointer_limit_ram_test
`default_nettype wire
